// [hdl/sic_top.sv]
// Purpose: Enable, priority and event logic for six interrupt sources, AHB-Lite registers
// Assumes: Source requests and core strobes come from logic on hclk
// Notes: Zero wait state slave; reserved bits are not stored and read as zero
//
// Function
// - With the global gate bit 7 clear no source passes; with it set each needs its enable.
// - Enable bit 5 lets the timer 2 request through.
// - Enable bit 4 lets the serial port request through.
// - Enable bit 3 lets the timer 1 request through.
// - Enable bit 2 lets the external pin 1 request through.
// - Enable bit 1 lets the timer 0 request through.
// - Enable bit 0 lets the external pin 0 request through.
// - Each source's priority comes from the high and low priority bits at its position.
// - Reserved bits carry no meaning and no logic depends on their read value.
// - The high and low bit pair gives levels 0 to 3, with 3 the highest.
// - Six sources over four levels, polled in order ext 0, timer 0, ext 1, timer 1, serial, timer 2.
`timescale 1ns/10ps
`default_nettype none
module sic_top (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  input wire sic_pkg::sic_vec_t src_req, // Raw requests, bit order of the enable register
  input wire logic core_ack, // Pulse: core has vectored the presented request
  input wire logic core_ret, // Pulse: core leaves the current service routine
  output logic core_irq, // A request is presented to the core
  output sic_pkg::sic_src_t core_src, // Source number presented
  output sic_pkg::sic_level_t core_level, // Level presented
  output logic irq // Level interrupt from unmasked event bits
);
  import sic_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic gate_q;
  sic_vec_t src_en_q;
  sic_vec_t prio_hi_q;
  sic_vec_t prio_lo_q;
  sic_vec_t evt_status_q;
  sic_vec_t evt_status_d;
  sic_vec_t evt_mask_q;
  sic_vec_t gated_q;
  logic [SIC_NLVL-1:0] svc_q;
  logic [SIC_NLVL-1:0] svc_d;
  logic core_irq_q;
  sic_src_t core_src_q;
  sic_level_t core_level_q;

  // ---------------------------------------------------------------
  // AHB-Lite address phase capture
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic [31:0] addr_q;
  wire logic take = hsel && hready && htrans[1];
  wire logic in_range = (addr_q[31:SIC_IDX_W+2] == '0) && (addr_q[1:0] == 2'b00);
  wire logic [SIC_IDX_W-1:0] idx = addr_q[SIC_IDX_W+1:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire logic hit_en = in_range && (idx == SIC_IDX_ENABLE);
  wire logic hit_ph = in_range && (idx == SIC_IDX_PRIO_HI);
  wire logic hit_pl = in_range && (idx == SIC_IDX_PRIO_LO);
  wire logic hit_st = in_range && (idx == SIC_IDX_EVT_STATUS);
  wire logic hit_mk = in_range && (idx == SIC_IDX_EVT_MASK);
  wire logic wr_en = wr_pend_q && hit_en;
  wire logic wr_ph = wr_pend_q && hit_ph;
  wire logic wr_pl = wr_pend_q && hit_pl;
  wire logic wr_st = wr_pend_q && hit_st;
  wire logic wr_mk = wr_pend_q && hit_mk;

  // ---------------------------------------------------------------
  // Enable and priority registers
  // ---------------------------------------------------------------
  // Reserved positions are simply not stored: a one written there is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q <= SIC_RST_ENABLE[SIC_BIT_GATE];
      src_en_q <= SIC_RST_ENABLE[SIC_NSRC-1:0];
      prio_hi_q <= SIC_RST_PRIO[SIC_NSRC-1:0];
      prio_lo_q <= SIC_RST_PRIO[SIC_NSRC-1:0];
    end else begin
      if (wr_en) begin
        gate_q <= hwdata[SIC_BIT_GATE];
        src_en_q <= hwdata[SIC_NSRC-1:0];
      end
      if (wr_ph) begin
        prio_hi_q <= hwdata[SIC_NSRC-1:0];
      end
      if (wr_pl) begin
        prio_lo_q <= hwdata[SIC_NSRC-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Named enable and priority fields
  // ---------------------------------------------------------------
  wire logic global_irq_gate = gate_q;
  wire logic timer2_irq_en = src_en_q[SIC_BIT_TIMER2];
  wire logic serial_irq_en = src_en_q[SIC_BIT_SERIAL];
  wire logic timer1_irq_en = src_en_q[SIC_BIT_TIMER1];
  wire logic pin_irq1_en = src_en_q[SIC_BIT_PIN1];
  wire logic timer0_irq_en = src_en_q[SIC_BIT_TIMER0];
  wire logic pin_irq0_en = src_en_q[SIC_BIT_PIN0];

  wire logic timer2_prio_hi = prio_hi_q[SIC_BIT_TIMER2];
  wire logic serial_prio_hi = prio_hi_q[SIC_BIT_SERIAL];
  wire logic timer1_prio_hi = prio_hi_q[SIC_BIT_TIMER1];
  wire logic pin_irq1_prio_hi = prio_hi_q[SIC_BIT_PIN1];
  wire logic timer0_prio_hi = prio_hi_q[SIC_BIT_TIMER0];
  wire logic pin_irq0_prio_hi = prio_hi_q[SIC_BIT_PIN0];
  wire logic timer2_prio_lo = prio_lo_q[SIC_BIT_TIMER2];
  wire logic serial_prio_lo = prio_lo_q[SIC_BIT_SERIAL];
  wire logic timer1_prio_lo = prio_lo_q[SIC_BIT_TIMER1];
  wire logic pin_irq1_prio_lo = prio_lo_q[SIC_BIT_PIN1];
  wire logic timer0_prio_lo = prio_lo_q[SIC_BIT_TIMER0];
  wire logic pin_irq0_prio_lo = prio_lo_q[SIC_BIT_PIN0];

  // ---------------------------------------------------------------
  // Request gating
  // ---------------------------------------------------------------
  sic_vec_t gated;
  assign gated[SIC_BIT_PIN0] = global_irq_gate && pin_irq0_en
                               && src_req[SIC_BIT_PIN0];
  assign gated[SIC_BIT_TIMER0] = global_irq_gate && timer0_irq_en
                                 && src_req[SIC_BIT_TIMER0];
  assign gated[SIC_BIT_PIN1] = global_irq_gate && pin_irq1_en
                               && src_req[SIC_BIT_PIN1];
  assign gated[SIC_BIT_TIMER1] = global_irq_gate && timer1_irq_en
                                 && src_req[SIC_BIT_TIMER1];
  assign gated[SIC_BIT_SERIAL] = global_irq_gate && serial_irq_en
                                 && src_req[SIC_BIT_SERIAL];
  assign gated[SIC_BIT_TIMER2] = global_irq_gate && timer2_irq_en
                                 && src_req[SIC_BIT_TIMER2];

  // ---------------------------------------------------------------
  // In-service levels
  // ---------------------------------------------------------------
  // Highest level currently in service; lower and equal requests wait behind it
  logic svc_any;
  sic_level_t svc_level;
  always_comb begin
    svc_any = 1'b0;
    svc_level = '0;
    for (int l = 0; l < SIC_NLVL; l++) begin
      if (svc_q[l]) begin
        svc_any = 1'b1;
        svc_level = sic_level_t'(l);
      end
    end
  end

  always_comb begin
    svc_d = svc_q;
    if (core_ret && svc_any) begin
      svc_d[svc_level] = 1'b0;
    end
    // An acknowledge in the same cycle as a return still enters service
    if (core_ack && core_irq_q) begin
      svc_d[core_level_q] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Resolver
  // ---------------------------------------------------------------
  sic_arb_if arb_bus ();
  assign arb_bus.req = gated;
  assign arb_bus.prio_hi = {timer2_prio_hi, serial_prio_hi, timer1_prio_hi,
                            pin_irq1_prio_hi, timer0_prio_hi, pin_irq0_prio_hi};
  assign arb_bus.prio_lo = {timer2_prio_lo, serial_prio_lo, timer1_prio_lo,
                            pin_irq1_prio_lo, timer0_prio_lo, pin_irq0_prio_lo};
  assign arb_bus.svc_any = svc_any;
  assign arb_bus.svc_level = svc_level;

  sic_resolver u_resolver (
    .arb(arb_bus.arb)
  );

  // ---------------------------------------------------------------
  // Core side and service tracking
  // ---------------------------------------------------------------
  // Presented request is held off for the cycle after an acknowledge so the
  // core never sees the same request twice before service is recorded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_q <= SIC_RST_SVC;
      core_irq_q <= 1'b0;
      core_src_q <= '0;
      core_level_q <= '0;
    end else begin
      svc_q <= svc_d;
      core_irq_q <= arb_bus.valid && !(core_ack && core_irq_q);
      core_src_q <= arb_bus.src;
      core_level_q <= arb_bus.level;
    end
  end

  assign core_irq = core_irq_q;
  assign core_src = core_src_q;
  assign core_level = core_level_q;

  // ---------------------------------------------------------------
  // Event status, mask and interrupt
  // ---------------------------------------------------------------
  // A new gated request sets its event bit; set beats a clear in the same cycle
  wire sic_vec_t evt_rise = gated & ~gated_q;
  assign evt_status_d = (evt_status_q & ~(wr_st ? hwdata[SIC_NSRC-1:0] : SIC_RST_VEC)) | evt_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gated_q <= SIC_RST_VEC;
      evt_status_q <= SIC_RST_VEC;
      evt_mask_q <= SIC_RST_VEC;
    end else begin
      gated_q <= gated;
      evt_status_q <= evt_status_d;
      if (wr_mk) begin
        evt_mask_q <= hwdata[SIC_NSRC-1:0];
      end
    end
  end

  assign irq = |(evt_status_q & evt_mask_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Reserved bits read as zero; software must not rely on that value
  wire logic [31:0] rd_en = {24'h00_0000, gate_q, 1'b0, src_en_q};
  wire logic [31:0] rd_ph = {26'h000_0000, prio_hi_q};
  wire logic [31:0] rd_pl = {26'h000_0000, prio_lo_q};
  wire logic [31:0] rd_st = {26'h000_0000, evt_status_q};
  wire logic [31:0] rd_mk = {26'h000_0000, evt_mask_q};
  wire logic [31:0] rd_vw = {20'h0_0000, svc_q, core_irq_q, 1'b0, core_level_q,
                             1'b0, core_src_q};
  // Read decode works on the address phase so that hrdata comes from a flop;
  // a write landing in that same cycle is not yet visible to the read
  wire logic rd_take = take && !hwrite;
  wire logic rd_ok = (haddr[31:SIC_IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
  wire logic [SIC_IDX_W-1:0] rd_idx = haddr[SIC_IDX_W+1:2];
  wire logic [31:0] rd_mux = !rd_ok ? 32'h0000_0000 :
                             (rd_idx == SIC_IDX_ENABLE) ? rd_en :
                             (rd_idx == SIC_IDX_PRIO_HI) ? rd_ph :
                             (rd_idx == SIC_IDX_PRIO_LO) ? rd_pl :
                             (rd_idx == SIC_IDX_EVT_STATUS) ? rd_st :
                             (rd_idx == SIC_IDX_EVT_MASK) ? rd_mk :
                             (rd_idx == SIC_IDX_VIEW) ? rd_vw : 32'h0000_0000;
  logic [31:0] hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= rd_take ? rd_mux : 32'h0000_0000;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // hsize is not decoded: only whole-word transfers are supported
  wire logic unused_size = ^hsize;

endmodule
`default_nettype wire

// [pkg/sic_pkg.sv]
// Purpose: Shared constants and types for the six-source interrupt control block
// Assumes: Sources are numbered by their bit position in the enable register
// Notes: Register offsets are indices; the byte address is four times the index
package sic_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned SIC_NSRC = 6;
  localparam int unsigned SIC_NLVL = 4;
  localparam int unsigned SIC_IDX_W = 8;

  typedef logic [SIC_NSRC-1:0] sic_vec_t;
  typedef logic [1:0] sic_level_t;
  typedef logic [2:0] sic_src_t;

  // ---------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_ENABLE = 8'ha8;
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_PRIO_HI = 8'hb7;
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_PRIO_LO = 8'hb8;
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_EVT_STATUS = 8'hc0;
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_EVT_MASK = 8'hc1;
  localparam logic [SIC_IDX_W-1:0] SIC_IDX_VIEW = 8'hc2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned SIC_BIT_GATE = 7;
  localparam int unsigned SIC_BIT_TIMER2 = 5;
  localparam int unsigned SIC_BIT_SERIAL = 4;
  localparam int unsigned SIC_BIT_TIMER1 = 3;
  localparam int unsigned SIC_BIT_PIN1 = 2;
  localparam int unsigned SIC_BIT_TIMER0 = 1;
  localparam int unsigned SIC_BIT_PIN0 = 0;
  localparam int unsigned SIC_VIEW_SRC_LSB = 0;
  localparam int unsigned SIC_VIEW_LVL_LSB = 4;
  localparam int unsigned SIC_VIEW_VALID_BIT = 7;
  localparam int unsigned SIC_VIEW_SVC_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SIC_RST_ENABLE = 8'h00;
  localparam logic [7:0] SIC_RST_PRIO = 8'h00;
  localparam sic_vec_t SIC_RST_VEC = 6'h00;
  localparam logic [SIC_NLVL-1:0] SIC_RST_SVC = 4'h0;

endpackage

// [pkg/sic_arb_if.sv]
// Purpose: Carries gated requests and priority bits to the resolver and its choice back
// Assumes: Same clock on both sides; all signals combinational
// Notes: ctl is the register side, arb is the resolver
`timescale 1ns/10ps
`default_nettype none
interface sic_arb_if;
  import sic_pkg::*;
  sic_vec_t req;
  sic_vec_t prio_hi;
  sic_vec_t prio_lo;
  logic svc_any;
  sic_level_t svc_level;
  logic valid;
  sic_src_t src;
  sic_level_t level;

  modport ctl (output req, prio_hi, prio_lo, svc_any, svc_level, input valid, src, level);
  modport arb (input req, prio_hi, prio_lo, svc_any, svc_level, output valid, src, level);
endinterface
`default_nettype wire

// [hdl/sic_resolver.sv]
// Purpose: Picks the pending request of highest level, ties by fixed polling order
// Assumes: Requests are already gated by the enable register
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
module sic_resolver (
  sic_arb_if.arb arb // Request in, choice out
);
  import sic_pkg::*;

  sic_level_t lvl [SIC_NSRC];
  sic_vec_t eligible;

  // ---------------------------------------------------------------
  // Per-source level and eligibility
  // ---------------------------------------------------------------
  for (genvar i = 0; i < SIC_NSRC; i++) begin : g_src
    assign lvl[i] = {arb.prio_hi[i], arb.prio_lo[i]};
    // A request only preempts when strictly above the level in service
    assign eligible[i] = arb.req[i] && (!arb.svc_any || (lvl[i] > arb.svc_level));
  end

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  always_comb begin
    arb.valid = 1'b0;
    arb.src = '0;
    arb.level = '0;
    // Walk from last to first so that an equal level found later (lower index) wins
    for (int i = SIC_NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!arb.valid || (lvl[i] >= arb.level))) begin
        arb.valid = 1'b1;
        arb.src = sic_src_t'(i);
        arb.level = lvl[i];
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/sic_core_model.sv]
// Purpose: Behavioural model of the core that accepts and retires presented requests
// Assumes: Runs on hclk; the bench commands every accept and every return
// Notes: An accept asked for while nothing is presented waits for the next request
`timescale 1ns/10ps
`default_nettype none
module sic_core_model (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Reset, active low
  input wire logic core_irq, // Request presented
  input wire logic ack_req, // Bench asks for one accept
  input wire logic ret_req, // Bench asks for one return
  output logic core_ack, // One-cycle accept pulse
  output logic core_ret // One-cycle return pulse
);
  logic pend_q;
  logic take;
  assign take = (pend_q | ack_req) & core_irq & !core_ack;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      core_ack <= 1'b0;
      core_ret <= 1'b0;
    end else begin
      pend_q <= (pend_q | ack_req) & !take;
      core_ack <= take;
      core_ret <= ret_req;
    end
  end
endmodule
`default_nettype wire

// [testbench/sic_top_chk.sv]
// Purpose: Port-level assertions for the interrupt control block
// Assumes: Zero wait state bus; results appear one edge after their cause
// Notes: Control registers are shadowed from the writes seen on the bus
`timescale 1ns/10ps
`default_nettype none
module sic_top_chk
  import sic_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire sic_pkg::sic_vec_t src_req, // Raw requests
  input wire logic core_ack, // Accept
  input wire logic core_ret, // Return
  input wire logic core_irq, // Presented
  input wire sic_pkg::sic_src_t core_src, // Source
  input wire sic_pkg::sic_level_t core_level, // Level
  input wire logic irq // Event interrupt
);
  import sic_pkg::*;
  logic act_p, wr_p;
  logic [31:0] a_p;
  logic [7:0] en_q, en_p;
  sic_vec_t ph_q, pl_q, ph_p, pl_p, g_q;
  sic_level_t exp_lvl;
  sic_src_t exp_src;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {act_p, wr_p, a_p, en_q, en_p} <= '0;
      {ph_q, pl_q, ph_p, pl_p, g_q} <= '0;
    end else begin
      act_p <= hsel & hready & htrans[1];
      wr_p <= hwrite;
      a_p <= haddr;
      {ph_p, pl_p} <= {ph_q, pl_q};
      en_p <= en_q;
      g_q <= en_q[7] ? (en_q[5:0] & src_req) : 6'h00;
      if (act_p && wr_p && a_p == 32'h2a0) en_q <= hwdata[7:0] & 8'hbf;
      if (act_p && wr_p && a_p == 32'h2dc) ph_q <= hwdata[5:0];
      if (act_p && wr_p && a_p == 32'h2e0) pl_q <= hwdata[5:0];
    end
  end
  // Scan from the last polled source down so that ties fall to the earliest
  always_comb begin
    exp_lvl = 2'h0;
    exp_src = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (g_q[i] && {ph_p[i], pl_p[i]} >= exp_lvl) begin
        exp_lvl = {ph_p[i], pl_p[i]};
        exp_src = 3'(i);
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_gate_blocks: assert property (g_q == 6'h00 |-> !core_irq)
    else $error("request presented with nothing enabled");
  a_src_enabled: assert property (core_irq |-> g_q[core_src])
    else $error("presented source not enabled and pending");
  a_src_range: assert property (core_irq |-> core_src < 3'h6)
    else $error("source number out of range");
  a_level_map: assert property (core_irq
    |-> core_level == {ph_p[core_src], pl_p[core_src]})
    else $error("level does not match priority bits");
  a_top_level: assert property (core_irq |-> core_level == exp_lvl)
    else $error("presented level is not the highest");
  a_poll_order: assert property (core_irq |-> core_src == exp_src)
    else $error("tie not broken by polling order");
  a_ack_drop: assert property (core_irq && core_ack |=> !core_irq)
    else $error("request still presented after accept");
  a_rd_enable: assert property (act_p && !wr_p && a_p == 32'h2a0
    |-> hrdata == {24'h0, en_p})
    else $error("enable register read back wrong");
endmodule
`default_nettype wire

// [testbench/test_sic_top.sv]
// Purpose: Self-checking bench for the interrupt control block
// Assumes: Single AHB-Lite master, core model on the far side
// Notes: Byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module test_sic_top;
  import sic_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  sic_vec_t src_req = 6'h00;
  logic ack_req = 1'b0;
  logic ret_req = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, core_irq, irq, core_ack, core_ret;
  sic_src_t core_src;
  sic_level_t core_level;
  int n_mismatch = 0;
  int total_checks = 0;
  always #50 hclk = ~hclk;
  sic_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req), .core_ack(core_ack),
    .core_ret(core_ret), .core_irq(core_irq), .core_src(core_src), .core_level(core_level),
    .irq(irq));
  sic_core_model core_u (.hclk(hclk), .hresetn(hresetn), .core_irq(core_irq),
    .ack_req(ack_req), .ret_req(ret_req), .core_ack(core_ack), .core_ret(core_ret));
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // A hung bus ends the run instead of stalling it
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pulse(input logic is_ack);
    @(posedge hclk);
    if (is_ack) ack_req <= 1'b1; else ret_req <= 1'b1;
    @(posedge hclk);
    {ack_req, ret_req} <= 2'h0;
    tick(4);
  endtask
  initial begin
    tick(8);
    hresetn <= 1'b1;
    ahb(0, 32'h2a0, 0); chk(rd, 0);
    ahb(0, 32'h2dc, 0); chk(rd, 0);
    ahb(0, 32'h2e0, 0); chk(rd, 0);
    ahb(1, 32'h104, 32'hff);
    ahb(0, 32'h104, 0); chk(rd, 0);
    ahb(1, 32'h2a1, 32'h3f);
    ahb(0, 32'h2a0, 0); chk(rd, 0);
    $display("test reset and map done");
    ahb(1, 32'h2a0, 32'h3f);
    src_req <= 6'h3f;
    tick(3); chk(core_irq, 0);
    for (int i = 0; i < 6; i++) begin
      ahb(1, 32'h2a0, 32'h80 | (32'h1 << i));
      tick(3); chk(core_irq, 1);
      chk(core_src, i);
      ahb(0, 32'h2a0, 0); chk(rd, 32'h80 | (32'h1 << i));
    end
    $display("test enables done");
    ahb(1, 32'h2a0, 32'h90);
    for (int lv = 0; lv < 4; lv++) begin
      ahb(1, 32'h2dc, 32'((lv / 2) * 16));
      ahb(1, 32'h2e0, 32'((lv % 2) * 16));
      tick(3); chk(core_level, lv);
      chk(core_src, 4);
    end
    $display("test levels done");
    ahb(1, 32'h2dc, 0);
    ahb(1, 32'h2e0, 0);
    ahb(1, 32'h2a0, 32'hbf);
    tick(3); chk(core_src, 0);
    ahb(1, 32'h2e0, 32'h24);
    tick(3); chk(core_src, 2);
    chk(core_level, 1);
    ahb(1, 32'h2dc, 32'h20);
    tick(3); chk(core_src, 5);
    chk(core_level, 3);
    pulse(1'b1);
    chk(core_irq, 0);
    ahb(0, 32'h308, 0); chk(rd[11:8], 4'h8);
    pulse(1'b0);
    chk(core_irq, 1);
    chk(core_src, 5);
    $display("test priority done");
    src_req <= 6'h00;
    tick(3);
    ahb(1, 32'h300, 32'h3f);
    ahb(1, 32'h304, 0);
    src_req <= 6'h02;
    tick(3);
    ahb(0, 32'h300, 0); chk(rd, 32'h02);
    chk(irq, 0);
    ahb(1, 32'h304, 32'h02);
    tick(2); chk(irq, 1);
    ahb(1, 32'h300, 32'h02);
    tick(2); chk(irq, 0);
    ahb(0, 32'h300, 0); chk(rd, 0);
    $display("test events done");
    report_and_stop();
  end
endmodule
bind sic_top sic_top_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
  .core_ack(core_ack), .core_ret(core_ret), .core_irq(core_irq), .core_src(core_src),
  .core_level(core_level), .irq(irq));
`default_nettype wire
